// >>> src/sdc_pkg.sv
// Shared widths, command codes, mode fields and power states of the SDRAM command interface
package sdc_pkg;

	// ------------------------------------------------------------
	// Array shape
	// ------------------------------------------------------------
	localparam int NBANK  = 4;
	localparam int BANK_W = 2;
	localparam int ROW_W  = 12;
	localparam int COL_W  = 9;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int LANES  = 2;
	localparam int ADDR_W = BANK_W + ROW_W + COL_W;
	localparam int CELLS  = NBANK * (1 << (ROW_W + COL_W));

	// ------------------------------------------------------------
	// Command codes as {chip select, row strobe, column strobe, write enable}
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_BST = 4'h6;

	// ------------------------------------------------------------
	// Mode word fields and address line roles
	// ------------------------------------------------------------
	localparam int MR_BL_LSB = 0;
	localparam int MR_BL_MSB = 2;
	localparam int MR_BT     = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_CL_MSB = 6;
	localparam int MR_WB     = 9;
	localparam int AP_LINE   = 10;

	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [2:0] CL_3    = 3'h3;

	localparam logic [COL_W-1:0] MASK_BL1  = 9'h000;
	localparam logic [COL_W-1:0] MASK_BL2  = 9'h001;
	localparam logic [COL_W-1:0] MASK_BL4  = 9'h003;
	localparam logic [COL_W-1:0] MASK_BL8  = 9'h007;
	localparam logic [COL_W-1:0] MASK_FULL = 9'h1FF;
	localparam logic [COL_W-1:0] COL_STEP  = 9'h001;

	// Burst of one, sequential order, latency two
	localparam logic [ROW_W-1:0] MODE_RESET = 12'h020;

	// ------------------------------------------------------------
	// Power modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SDC_PM_RUN  = 2'h0,
		SDC_PM_DOWN = 2'h1,
		SDC_PM_SELF = 2'h2
	} sdc_pm_e;

endpackage

// >>> src/sdc_store.sv
// Cell array of the SDRAM: four banks of rows and columns, byte-lane writes
`timescale 1ns/10ps
`default_nettype none

module sdc_store (
	input  wire logic                             sys_clk,
	input  wire logic                             wr_en,
	input  wire logic [sdc_pkg::LANES-1:0]        wr_be,
	input  wire logic [sdc_pkg::ADDR_W-1:0]       wr_addr,
	input  wire logic [sdc_pkg::DATA_W-1:0]       wr_data,
	input  wire logic [sdc_pkg::ADDR_W-1:0]       rd_addr,
	output logic      [sdc_pkg::DATA_W-1:0]       rd_data
);

	// Index is {bank, row, column}, so each bank holds 2M words
	logic [sdc_pkg::DATA_W-1:0] cells [sdc_pkg::CELLS];

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < sdc_pkg::LANES; i++) begin
			if (wr_en && wr_be[i]) begin
				cells[wr_addr][i*sdc_pkg::BYTE_W +: sdc_pkg::BYTE_W] <= wr_data[i*sdc_pkg::BYTE_W +: sdc_pkg::BYTE_W];
			end
		end
	end

	assign rd_data = cells[rd_addr];

endmodule
`default_nettype wire

// >>> src/sdc_device.sv
// Command decoder, bank state, burst engine, latency pipe and power modes of the SDRAM
//
// Summary of operation
// - All commands, addresses and data are taken on the rising clock edge.
// - The array is four independent banks of 2M sixteen-bit words.
// - A burst starts at the given column and runs the programmed count and order.
// - Burst length is 1, 2, 4, 8 or full page; bursts can be cut short.
// - Auto precharge closes the row by itself when the burst ends.
// - Read data appears two or three cycles after the read command.
// - Burst order is either interleaved or sequential.
// - Only active edges advance the burst counter and the output register.
// - Clock enable low freezes outputs and burst address from the next cycle.
// - Clock enable low with all banks idle enters power-down or self refresh.
// - In low-power modes inputs are off and clock enable is an async wake.
// - The two bank selects pick banks 0 to 3, high bit first.
// - Address carries the row at activation; column and auto-precharge at access.
// - Precharge with line 10 high closes all banks, else the selected one.
// - Mode register set takes its operating code from the address lines.
// - Chip select high ignores new commands; running operations go on.
// - Chip select is part of the command code.
// - Row strobe low, column strobe high, write enable high opens a row.
// - Row strobe low, column strobe high, write enable low precharges a bank.
// - Column strobe low, row strobe high: write enable picks read or write.
// - Byte masks turn off read drivers and block writes per byte lane.
`timescale 1ns/10ps
`default_nettype none

module sdc_device (
	input  wire logic                             sys_clk,
	input  wire logic                             rst,
	input  wire logic                             cke,
	input  wire logic                             cs_n,
	input  wire logic                             ras_n,
	input  wire logic                             cas_n,
	input  wire logic                             we_n,
	input  wire logic                             bank_sel_lo,
	input  wire logic                             bank_sel_hi,
	input  wire logic [sdc_pkg::ROW_W-1:0]        addr,
	input  wire logic                             low_byte_mask,
	input  wire logic                             high_byte_mask,
	input  wire logic [sdc_pkg::DATA_W-1:0]       data_lines_in,
	output logic      [sdc_pkg::DATA_W-1:0]       data_lines_out,
	output logic      [sdc_pkg::LANES-1:0]        data_lines_oe,
	output logic      [sdc_pkg::NBANK-1:0]        bank_open,
	output logic                                  power_down,
	output logic                                  self_refresh,
	output logic                                  clock_suspended
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [sdc_pkg::COL_W-1:0] burst_mask(input logic [2:0] bl);
		logic [sdc_pkg::COL_W-1:0] m;
		m = sdc_pkg::MASK_BL1;
		case (bl)
			sdc_pkg::BL_2:    m = sdc_pkg::MASK_BL2;
			sdc_pkg::BL_4:    m = sdc_pkg::MASK_BL4;
			sdc_pkg::BL_8:    m = sdc_pkg::MASK_BL8;
			sdc_pkg::BL_FULL: m = sdc_pkg::MASK_FULL;
			default:          m = sdc_pkg::MASK_BL1;
		endcase
		return m;
	endfunction

	// Column of burst word idx; wraps inside the aligned block of the burst length
	function automatic logic [sdc_pkg::COL_W-1:0] burst_col(
		input logic [sdc_pkg::COL_W-1:0] start,
		input logic [sdc_pkg::COL_W-1:0] idx,
		input logic [2:0]                bl,
		input logic                      ilv
	);
		logic [sdc_pkg::COL_W-1:0] m;
		logic [sdc_pkg::COL_W-1:0] off;
		m = burst_mask(bl);
		if (ilv && bl != sdc_pkg::BL_FULL) begin
			off = start ^ idx;
		end else begin
			off = sdc_pkg::COL_W'(start + idx);
		end
		return (start & ~m) | (off & m);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic                          cke_prev;
	logic                          cke_s1;
	logic                          cke_s2;
	logic                          cke_s3;
	logic                          wake_armed;
	sdc_pkg::sdc_pm_e              pm;
	sdc_pkg::sdc_pm_e              next_pm;
	logic [sdc_pkg::ROW_W-1:0]     mode;
	logic [sdc_pkg::ROW_W-1:0]     bank_row [sdc_pkg::NBANK];
	logic                          rd_active;
	logic                          wr_active;
	logic [sdc_pkg::BANK_W-1:0]    burst_bank;
	logic [sdc_pkg::ROW_W-1:0]     burst_row;
	logic [sdc_pkg::COL_W-1:0]     burst_start;
	logic [sdc_pkg::COL_W-1:0]     burst_cnt;
	logic                          burst_ap;
	logic [sdc_pkg::DATA_W-1:0]    p1_data;
	logic                          p1_valid;
	logic                          out_valid;
	logic [sdc_pkg::LANES-1:0]     dqm_q;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic                          act_edge;
	logic                          low_power;
	logic [3:0]                    cmd;
	logic [sdc_pkg::BANK_W-1:0]    sel_bank;
	logic                          is_act;
	logic                          is_pre;
	logic                          is_rd;
	logic                          is_wr;
	logic                          is_mrs;
	logic                          is_ref;
	logic                          is_bst;
	logic                          all_idle;
	logic [2:0]                    bl;
	logic                          cl3;
	logic                          wr_single;
	logic                          term_pre;
	logic                          burst_last;
	logic                          burst_end;
	logic [sdc_pkg::COL_W-1:0]     cur_col;

	// Clock enable sampled at the previous edge gates this edge
	assign low_power = (pm != sdc_pkg::SDC_PM_RUN);
	assign act_edge  = cke_prev && !low_power;
	assign cmd       = {cs_n, ras_n, cas_n, we_n};
	assign sel_bank  = {bank_sel_hi, bank_sel_lo};
	assign is_act    = act_edge && (cmd == sdc_pkg::CMD_ACT);
	assign is_pre    = act_edge && (cmd == sdc_pkg::CMD_PRE);
	assign is_rd     = act_edge && (cmd == sdc_pkg::CMD_RD);
	assign is_wr     = act_edge && (cmd == sdc_pkg::CMD_WR);
	assign is_mrs    = act_edge && (cmd == sdc_pkg::CMD_MRS);
	assign is_ref    = act_edge && (cmd == sdc_pkg::CMD_REF);
	assign is_bst    = act_edge && (cmd == sdc_pkg::CMD_BST);
	assign all_idle  = (bank_open == '0);
	assign bl        = mode[sdc_pkg::MR_BL_MSB:sdc_pkg::MR_BL_LSB];
	assign cl3       = (mode[sdc_pkg::MR_CL_MSB:sdc_pkg::MR_CL_LSB] == sdc_pkg::CL_3);
	assign wr_single = mode[sdc_pkg::MR_WB] || (burst_mask(bl) == sdc_pkg::MASK_BL1);
	assign term_pre  = is_pre && (addr[sdc_pkg::AP_LINE] || sel_bank == burst_bank);
	// Full page never ends by itself, only by a stop, a precharge of its bank or of all banks, or a new access
	assign burst_last = (bl != sdc_pkg::BL_FULL) && (burst_cnt == burst_mask(bl));
	assign burst_end  = act_edge && (rd_active || wr_active) && burst_last
	                    && !is_rd && !is_wr && !is_bst && !term_pre;
	assign cur_col    = burst_col(burst_start, burst_cnt, bl, mode[sdc_pkg::MR_BT]);

	// ------------------------------------------------------------
	// Cell array
	// ------------------------------------------------------------
	logic                          st_we;
	logic [sdc_pkg::LANES-1:0]     st_be;
	logic [sdc_pkg::ADDR_W-1:0]    st_waddr;
	logic [sdc_pkg::DATA_W-1:0]    rd_data;

	// First write word is taken with the command itself, masks with zero latency
	always_comb begin
		st_we    = 1'b0;
		st_be    = ~{high_byte_mask, low_byte_mask};
		st_waddr = {burst_bank, burst_row, cur_col};
		if (is_wr) begin
			st_we    = 1'b1;
			st_waddr = {sel_bank, bank_row[sel_bank], addr[sdc_pkg::COL_W-1:0]};
		end else if (act_edge && wr_active && !is_rd && !is_bst && !term_pre) begin
			// The word on the lines at a cutting read, stop or precharge belongs to no burst
			st_we    = 1'b1;
		end
	end

	sdc_store i_sdc_store (
		.sys_clk (sys_clk),
		.wr_en   (st_we),
		.wr_be   (st_be),
		.wr_addr (st_waddr),
		.wr_data (data_lines_in),
		.rd_addr ({burst_bank, burst_row, cur_col}),
		.rd_data (rd_data)
	);

	// ------------------------------------------------------------
	// Clock enable sampling and wake synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cke_prev <= 1'b0;
		end else begin
			cke_prev <= cke;
		end
	end

	// With the input buffers off, clock enable is treated as asynchronous
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cke_s1 <= 1'b0;
			cke_s2 <= 1'b0;
			cke_s3 <= 1'b0;
		end else begin
			cke_s1 <= cke;
			cke_s2 <= cke_s1;
			cke_s3 <= cke_s2;
		end
	end

	// ------------------------------------------------------------
	// Power modes
	// ------------------------------------------------------------
	always_comb begin
		next_pm = pm;
		unique case (pm)
			sdc_pkg::SDC_PM_RUN: begin
				if (cke_prev && !cke && all_idle && !rd_active && !wr_active) begin
					next_pm = is_ref ? sdc_pkg::SDC_PM_SELF : sdc_pkg::SDC_PM_DOWN;
				end
			end
			sdc_pkg::SDC_PM_DOWN,
			sdc_pkg::SDC_PM_SELF: begin
				if (wake_armed && cke_s2 && cke_s3) begin
					next_pm = sdc_pkg::SDC_PM_RUN;
				end
			end
			default: next_pm = sdc_pkg::SDC_PM_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pm              <= sdc_pkg::SDC_PM_RUN;
			power_down      <= 1'b0;
			self_refresh    <= 1'b0;
			clock_suspended <= 1'b0;
		end else begin
			pm              <= next_pm;
			power_down      <= (next_pm == sdc_pkg::SDC_PM_DOWN);
			self_refresh    <= (next_pm == sdc_pkg::SDC_PM_SELF);
			clock_suspended <= !cke && (next_pm == sdc_pkg::SDC_PM_RUN);
		end
	end

	// The synchroniser still holds the pre-entry high; wait for a settled low first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_armed <= 1'b0;
		end else if (!low_power) begin
			wake_armed <= 1'b0;
		end else if (!cke_s2 && !cke_s3) begin
			wake_armed <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Mode register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode <= sdc_pkg::MODE_RESET;
		end else if (is_mrs && all_idle) begin
			mode <= addr;
		end
	end

	// ------------------------------------------------------------
	// Bank state
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bank_open <= '0;
		end else if (act_edge) begin
			if (burst_end && burst_ap) begin
				bank_open[burst_bank] <= 1'b0;
			end
			if (is_wr && addr[sdc_pkg::AP_LINE] && wr_single) begin
				bank_open[sel_bank] <= 1'b0;
			end
			if (is_act && !bank_open[sel_bank]) begin
				bank_open[sel_bank] <= 1'b1;
			end
			if (is_pre) begin
				if (addr[sdc_pkg::AP_LINE]) begin
					bank_open <= '0;
				end else begin
					bank_open[sel_bank] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < sdc_pkg::NBANK; i++) begin
				bank_row[i] <= '0;
			end
		end else if (is_act && !bank_open[sel_bank]) begin
			bank_row[sel_bank] <= addr;
		end
	end

	// ------------------------------------------------------------
	// Burst engine
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_active   <= 1'b0;
			wr_active   <= 1'b0;
			burst_bank  <= '0;
			burst_row   <= '0;
			burst_start <= '0;
			burst_cnt   <= '0;
			burst_ap    <= 1'b0;
		end else if (act_edge) begin
			if (is_rd || is_wr) begin
				// A new access cuts any running burst short
				rd_active   <= is_rd;
				wr_active   <= is_wr && !wr_single;
				burst_bank  <= sel_bank;
				burst_row   <= bank_row[sel_bank];
				burst_start <= addr[sdc_pkg::COL_W-1:0];
				burst_cnt   <= is_wr ? sdc_pkg::COL_STEP : '0;
				burst_ap    <= addr[sdc_pkg::AP_LINE];
			end else if (is_bst || term_pre) begin
				rd_active <= 1'b0;
				wr_active <= 1'b0;
			end else if (rd_active || wr_active) begin
				if (burst_last) begin
					rd_active <= 1'b0;
					wr_active <= 1'b0;
				end else begin
					burst_cnt <= sdc_pkg::COL_W'(burst_cnt + sdc_pkg::COL_STEP);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read latency pipe and output drivers
	// ------------------------------------------------------------
	logic next_valid;
	assign next_valid = cl3 ? p1_valid : rd_active;

	// Mask on reads acts two edges later, hence the extra mask stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			p1_data        <= '0;
			p1_valid       <= 1'b0;
			dqm_q          <= '0;
			out_valid      <= 1'b0;
			data_lines_out <= '0;
			data_lines_oe  <= '0;
		end else if (act_edge) begin
			p1_data        <= rd_data;
			p1_valid       <= rd_active;
			dqm_q          <= {high_byte_mask, low_byte_mask};
			out_valid      <= next_valid;
			data_lines_out <= cl3 ? p1_data : rd_data;
			data_lines_oe  <= {sdc_pkg::LANES{next_valid}} & ~dqm_q;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_cl2_latency: assert property (@(posedge sys_clk) disable iff (rst)
		(act_edge && is_rd && !cl3) ##1 act_edge |=> out_valid)
		else $error("read data missing two cycles after read at latency two");

	a_cl3_latency: assert property (@(posedge sys_clk) disable iff (rst)
		(act_edge && is_rd && cl3) ##1 act_edge ##1 act_edge |=> out_valid)
		else $error("read data missing three cycles after read at latency three");

	a_suspend_freeze: assert property (@(posedge sys_clk) disable iff (rst)
		!act_edge |=> $stable(data_lines_out) && $stable(burst_cnt) && $stable(data_lines_oe))
		else $error("outputs or burst address moved while the clock was suspended");

	a_pd_entry: assert property (@(posedge sys_clk) disable iff (rst)
		(pm == sdc_pkg::SDC_PM_RUN) && cke_prev && !cke && all_idle && !rd_active && !wr_active
		|=> ($past(is_ref) ? self_refresh : power_down))
		else $error("idle device did not enter power-down or self refresh");

	a_wake_exit: assert property (@(posedge sys_clk) disable iff (rst)
		low_power && wake_armed && cke_s2 && cke_s3 |=> !power_down && !self_refresh && !low_power)
		else $error("low-power mode not left after clock enable rose");

	a_pre_all: assert property (@(posedge sys_clk) disable iff (rst)
		is_pre && addr[sdc_pkg::AP_LINE] |=> bank_open == '0)
		else $error("precharge all left a bank open");

	a_row_open: assert property (@(posedge sys_clk) disable iff (rst)
		is_act && !bank_open[sel_bank] |=> bank_open[$past(sel_bank)] && bank_row[$past(sel_bank)] == $past(addr))
		else $error("activation did not open the addressed row");

	a_mode_load: assert property (@(posedge sys_clk) disable iff (rst)
		is_mrs && all_idle |=> mode == $past(addr))
		else $error("mode register did not take the address lines");

	a_cs_ignore: assert property (@(posedge sys_clk) disable iff (rst)
		act_edge && cs_n && !burst_end |=> $stable(bank_open) && $stable(mode))
		else $error("deselected device changed bank or mode state");

	a_auto_close: assert property (@(posedge sys_clk) disable iff (rst)
		burst_end && burst_ap && !(is_act && sel_bank == burst_bank) |=> !bank_open[$past(burst_bank)])
		else $error("auto precharge did not close the bank at burst end");

	a_read_mask: assert property (@(posedge sys_clk) disable iff (rst)
		act_edge && low_byte_mask ##1 act_edge |=> !data_lines_oe[0])
		else $error("low byte driven despite its read mask");

endmodule
`default_nettype wire

// >>> tb/sdc_ctrl_model.sv
// Controller model that drives commands, addresses, masks and write data
`timescale 1ns/10ps
`default_nettype none

module sdc_ctrl_model (
	input  wire logic        sys_clk,
	output logic             cke,
	output logic             cs_n,
	output logic             ras_n,
	output logic             cas_n,
	output logic             we_n,
	output logic             bank_sel_lo,
	output logic             bank_sel_hi,
	output logic [11:0]      addr,
	output logic             low_byte_mask,
	output logic             high_byte_mask,
	output logic [15:0]      data_lines_in
);
	initial begin
		cke = 1'b0;
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		{bank_sel_hi, bank_sel_lo, addr, high_byte_mask, low_byte_mask, data_lines_in} = '0;
	end

	// Launched just after an edge, held until the next edge takes it
	task automatic send(input logic [3:0] code, input logic [1:0] bank, input logic [11:0] a,
		input logic [15:0] d, input logic [1:0] m);
		@(posedge sys_clk);
		{cs_n, ras_n, cas_n, we_n} <= code;
		{bank_sel_hi, bank_sel_lo} <= bank;
		addr <= a;
		data_lines_in <= d;
		{high_byte_mask, low_byte_mask} <= m;
	endtask

	// Clock enable is launched on an edge like every other input
	task automatic set_cke(input logic v);
		cke <= v;
	endtask
endmodule

`default_nettype wire

// >>> tb/sdc_device_tb.sv
// Self-checking bench for the SDRAM command interface
`timescale 1ns/10ps
`default_nettype none

module sdc_device_tb;
	typedef struct packed {
		logic [15:0] word;
		logic [15:0] at;
		logic [1:0]  lanes;
	} sdc_exp_s;
	logic             sys_clk;
	logic             rst;
	wire logic        cke, cs_n, ras_n, cas_n, we_n, bank_sel_lo, bank_sel_hi;
	wire logic        low_byte_mask, high_byte_mask, power_down, self_refresh, clock_suspended;
	wire logic [11:0] addr;
	wire logic [15:0] data_lines_in, data_lines_out;
	wire logic [1:0]  data_lines_oe;
	wire logic [3:0]  bank_open;
	sdc_exp_s         exp_q[$];
	sdc_exp_s         e;
	logic [15:0]      mem [512];
	logic [31:0]      lfsr;
	logic [15:0]      lm;
	int unsigned      cyc = 0;
	int unsigned      num_errors = 0;
	int unsigned      check_count = 0;

	sdc_ctrl_model i_sdc_ctrl_model (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel_lo,
		.bank_sel_hi, .addr, .low_byte_mask, .high_byte_mask, .data_lines_in);
	sdc_device i_sdc_device (.sys_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel_lo,
		.bank_sel_hi, .addr, .low_byte_mask, .high_byte_mask, .data_lines_in, .data_lines_out,
		.data_lines_oe, .bank_open, .power_down, .self_refresh, .clock_suspended);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Counted on the falling edge so the rising-edge drivers read it without a race
	always @(negedge sys_clk) cyc <= cyc + 1;

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic give_verdict();
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_state(input logic [3:0] bo, input logic [2:0] pm);
		check_word({9'h000, bank_open, power_down, self_refresh, clock_suspended}, {9'h000, bo, pm});
	endtask

	// Idle data lines carry fresh random words so a stale value cannot pass
	task automatic op(input logic [3:0] code, input logic [1:0] b, input logic [11:0] a);
		lfsr = lfsr_next(lfsr);
		i_sdc_ctrl_model.send(code, b, a, lfsr[15:0], 2'h0);
	endtask

	task automatic wait_n(input int n);
		repeat (n) op(4'h7, 2'h0, 12'h000);
	endtask

	// Runs n beats of a burst of length bl; fewer beats than bl leaves it to be cut short
	task automatic burst(input logic wr, input logic [1:0] b, input logic [8:0] col, input logic ap,
		input int bl, input int n, input int cl, input logic ilv, input logic [1:0] mk);
		logic [8:0] c;
		logic [8:0] w;
		logic [1:0] m;
		for (int i = 0; i < n; i++) begin
			w = 9'(bl - 1);
			c = ilv ? col ^ 9'(i) : (col & ~w) | ((col + 9'(i)) & w);
			m = (i == 1) ? mk : 2'h0;
			lfsr = lfsr_next(lfsr);
			if (wr && !m[0]) mem[c][7:0] = lfsr[7:0];
			if (wr && !m[1]) mem[c][15:8] = lfsr[15:8];
			i_sdc_ctrl_model.send(i != 0 ? 4'h7 : wr ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD, b,
				{1'b0, ap, 1'b0, col}, lfsr[15:0], m);
			// At latency two a read mask pairs with the word of its own beat
			if (!wr) exp_q.push_back('{mem[c], 16'(cyc + cl), ~m});
		end
	endtask

	always @(negedge sys_clk) begin
		if (!rst && data_lines_oe !== 2'h0) begin
			if (exp_q.size() == 0) begin
				check_word(16'h0000, 16'h0001);
			end else begin
				e = exp_q.pop_front();
				lm = {{8{e.lanes[1]}}, {8{e.lanes[0]}}};
				check_word(data_lines_out & lm, e.word & lm);
				check_word({14'h0000, data_lines_oe}, {14'h0000, e.lanes});
				check_word(cyc[15:0], e.at);
			end
		end
	end

	initial begin
		#20000;
		num_errors++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		lfsr = 32'h61E0D490;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		i_sdc_ctrl_model.set_cke(1'b1);
		wait_n(2);
		op(sdc_pkg::CMD_MRS, 2'h0, 12'h022);
		op(sdc_pkg::CMD_ACT, 2'h2, 12'h005);
		op(4'hB, 2'h0, 12'h005);
		wait_n(2);
		check_state(4'h4, 3'h0);
		burst(1'b1, 2'h2, 9'h002, 1'b0, 4, 4, 2, 1'b0, 2'h0);
		burst(1'b1, 2'h2, 9'h000, 1'b0, 4, 4, 2, 1'b0, 2'h2);
		burst(1'b0, 2'h2, 9'h000, 1'b0, 4, 4, 2, 1'b0, 2'h0);
		burst(1'b0, 2'h2, 9'h001, 1'b0, 4, 1, 2, 1'b0, 2'h0);
		burst(1'b0, 2'h2, 9'h002, 1'b0, 4, 4, 2, 1'b0, 2'h0);
		burst(1'b0, 2'h2, 9'h000, 1'b0, 4, 4, 2, 1'b0, 2'h1);
		wait_n(6);
		op(sdc_pkg::CMD_PRE, 2'h2, 12'h000);
		op(sdc_pkg::CMD_ACT, 2'h1, 12'h007);
		wait_n(2);
		check_state(4'h2, 3'h0);
		op(sdc_pkg::CMD_PRE, 2'h0, 12'h400);
		wait_n(2);
		check_state(4'h0, 3'h0);
		op(sdc_pkg::CMD_MRS, 2'h0, 12'h03A);
		op(sdc_pkg::CMD_ACT, 2'h2, 12'h005);
		burst(1'b0, 2'h2, 9'h001, 1'b1, 4, 4, 3, 1'b1, 2'h0);
		wait_n(7);
		check_state(4'h0, 3'h0);
		op(sdc_pkg::CMD_MRS, 2'h0, 12'h227);
		op(sdc_pkg::CMD_ACT, 2'h2, 12'h005);
		burst(1'b1, 2'h2, 9'h004, 1'b0, 512, 1, 2, 1'b0, 2'h0);
		burst(1'b0, 2'h2, 9'h001, 1'b0, 512, 4, 2, 1'b0, 2'h0);
		op(sdc_pkg::CMD_BST, 2'h2, 12'h000);
		op(sdc_pkg::CMD_PRE, 2'h2, 12'h000);
		wait_n(4);
		check_state(4'h0, 3'h0);
		i_sdc_ctrl_model.set_cke(1'b0);
		wait_n(3);
		check_state(4'h0, 3'h4);
		i_sdc_ctrl_model.set_cke(1'b1);
		wait_n(8);
		check_state(4'h0, 3'h0);
		op(sdc_pkg::CMD_REF, 2'h0, 12'h000);
		i_sdc_ctrl_model.set_cke(1'b0);
		wait_n(3);
		check_state(4'h0, 3'h2);
		i_sdc_ctrl_model.set_cke(1'b1);
		wait_n(8);
		op(sdc_pkg::CMD_ACT, 2'h3, 12'h001);
		wait_n(1);
		i_sdc_ctrl_model.set_cke(1'b0);
		wait_n(3);
		check_state(4'h8, 3'h1);
		i_sdc_ctrl_model.set_cke(1'b1);
		wait_n(2);
		check_word(16'(exp_q.size()), 16'h0000);
		give_verdict();
	end
endmodule

`default_nettype wire
